// ===== post_div_pkg.sv
// Purpose: shared constants and types for the output post-divider block
// Assumes: APB word index = printed register offset, byte address = 4 * index
// Notes:   24-bit channel words sit in the low bits of the 32-bit data bus
package post_div_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // channel configuration word layout
   typedef struct packed {
      logic [3:0]  shape;                     // all ones = frame pulse
      logic        ptype;                     // 0 mid-pulse, 1 edge boundary
      logic        pol;                       // 1 = inverted pulse
      logic [1:0]  sel;                       // related clock code
      logic [15:0] period;                    // related periods between pulses
   } cfg_t;

   ////////////////////////////////////////////////////////////////////////////
   // register indices, byte address is four times the index
   localparam int          NCH       = 2;                 // channels covered
   localparam logic [7:0]  IDX_S1D   = 8'h95;             // synth1 divider D
   localparam logic [7:0]  IDX_S2A   = 8'h98;             // synth2 divider A
   localparam logic [7:0]  IDX_ROUTE = 8'hC0;             // pin routing bits
   localparam logic [7:0]  IDX_STAT  = 8'hC1;             // block status
   localparam logic [23:0] RST_S1D   = 24'h000032;        // synth1 D reset
   localparam logic [23:0] RST_S2A   = 24'h000000;        // synth2 A reset
   localparam logic [3:0]  SHAPE_FP  = 4'hF;              // frame pulse code
   localparam logic [23:0] MAX_DIV   = 24'hEFFFFF;        // normal ceiling
   localparam logic [1:0]  RSV_S1D   = 2'h3;              // reserved code, 1D
   localparam logic [1:0]  RSV_S2A   = 2'h0;              // reserved code, 2A
   localparam logic [2:0]  ALL_LANES = 3'h7;              // three word bytes

endpackage

// ===== post_div_channel.sv
// Purpose: one post-divider output, clock divider or frame pulse generator
// Assumes: vcoTick is a one-cycle enable, related clocks are sync levels
// Notes:   output lags the internal state by one flop stage
module post_div_channel
   import post_div_pkg::*;
#(
   parameter logic [1:0] RSV_SEL = 2'h0       // reserved related-clock code
) (
   input  wire logic       clk,               // system clock
   input  wire logic       rst,               // async reset, active high
   input  wire cfg_t       cfg,               // committed configuration
   input  wire logic       vcoTick,           // one VCO period elapsed
   input  wire logic [3:0] relClk,            // related clocks by code
   input  wire logic       invert,            // routed to configurable pin
   output logic            clkOut             // divided clock or frame pulse
);

   logic [23:0] divCnt_r;                     // VCO tick counter
   logic [15:0] pCnt_r;                       // related period counter
   logic        relPrev_r;                    // related level last cycle
   logic        pulse_r;                      // raw frame pulse
   wire  [23:0] divN    = cfg;                // whole word as divisor
   wire  [23:0] hiLen   = divN - (divN >> 1); // high half, longer when odd
   wire         fpMode  = cfg.shape == SHAPE_FP;
   wire         relLvl  = relClk[cfg.sel];
   wire         rise    = relLvl & ~relPrev_r;
   wire         fall    = ~relLvl & relPrev_r;
   wire         live    = fpMode && cfg.sel != RSV_SEL && cfg.period != 16'h0000;
   wire         divWrap = {1'b0, divCnt_r} + 25'h0000001 >= {1'b0, divN};
   wire         lastCnt = {1'b0, pCnt_r} + 17'h00001 >= {1'b0, cfg.period};
   wire         divClk  = divCnt_r < hiLen;   // 50% duty clock when divN is even

   ////////////////////////////////////////////////////////////////////////////
   // counters and pulse; a stopped related clock just freezes the frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divCnt_r  <= 24'h000000;
         pCnt_r    <= 16'h0000;
         relPrev_r <= 1'b0;
         pulse_r   <= 1'b0;
         clkOut    <= 1'b0;
      end else begin
         relPrev_r <= relLvl;
         if (vcoTick) divCnt_r <= divWrap ? 24'h000000 : divCnt_r + 24'h000001;
         if (rise) pCnt_r <= lastCnt ? 16'h0000 : pCnt_r + 16'h0001;
         if (!live) pulse_r <= 1'b0;
         else if (cfg.ptype) begin
            if (rise) pulse_r <= lastCnt;
         end else begin
            if (fall) pulse_r <= lastCnt;
         end
         clkOut <= fpMode ? pulse_r ^ cfg.pol ^ invert : divClk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_gci_start;
      live && cfg.ptype && rise && lastCnt |=> pulse_r;
   endproperty
   a_gci_start: assert property (p_gci_start) else $error("gci pulse missed");

   property p_st_start;
      live && !cfg.ptype && rise && !pulse_r |=> !pulse_r;
   endproperty
   a_st_start: assert property (p_st_start) else $error("st pulse on rise");

   property p_width;
      live && cfg.ptype && pulse_r && rise && !lastCnt ##1 $stable(cfg) |-> !pulse_r;
   endproperty
   a_width: assert property (p_width) else $error("pulse too long");

   property p_space;
      rise && !lastCnt |=> pCnt_r == $past(pCnt_r) + 16'h0001;
   endproperty
   a_space: assert property (p_space) else $error("period count slip");

   property p_reserved;
      fpMode && cfg.sel == RSV_SEL |=> !pulse_r;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved select pulsed");

   property p_polarity;
      fpMode && !invert && $stable(cfg) ##1 $stable(cfg) |-> clkOut == ($past(pulse_r) ^ cfg.pol);
   endproperty
   a_polarity: assert property (p_polarity) else $error("bad pulse polarity");

   property p_pin_flip;
      fpMode && invert && !cfg.pol ##1 fpMode |-> clkOut != $past(pulse_r);
   endproperty
   a_pin_flip: assert property (p_pin_flip) else $error("pin route not inverted");

   property p_divide;
      !fpMode && vcoTick && divWrap ##1 !fpMode && divN != 24'h000000
      |-> divCnt_r == 24'h000000 ##1 clkOut;
   endproperty
   a_divide: assert property (p_divide) else $error("divider wrap wrong");

   property p_shape;
      !fpMode ##1 !fpMode |-> clkOut == $past(divClk);
   endproperty
   a_shape: assert property (p_shape) else $error("normal output wrong");

endmodule

// ===== post_div_top.sv
// Purpose: APB register file and two post-divider outputs
// Assumes: all inputs synchronous to clk; ticks are one-cycle enables
// Notes:   zero-wait slave, answers one cycle into the access phase
//
// Added by the designer: the APB register port.
module post_div_top
   import post_div_pkg::*;
(
   input  wire logic        clk,              // 200 MHz system clock
   input  wire logic        rst,              // async reset, active high
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB access phase
   input  wire logic        pwrite,           // APB write
   input  wire logic [9:0]  paddr,            // APB byte address
   input  wire logic [31:0] pwdata,           // APB write data
   input  wire logic [3:0]  pstrb,            // APB byte strobes
   output logic      [31:0] prdata,           // APB read data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB unmapped address
   input  wire logic        vco1Tick,         // synth1 VCO period enable
   input  wire logic        vco2Tick,         // synth2 VCO period enable
   input  wire logic        s1RelA,           // synth1 divider A output
   input  wire logic        s1RelB,           // synth1 divider B output
   input  wire logic        s1RelC,           // synth1 divider C output
   input  wire logic        s2RelB,           // synth2 divider B output
   input  wire logic        s2RelC,           // synth2 divider C output
   input  wire logic        s2RelD,           // synth2 divider D output
   output logic             synth1DivisorD,   // synth1 divider D output
   output logic             synth2DivisorA    // synth2 divider A output
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire  [7:0]  idx     = paddr[9:2];         // register index
   wire         setup   = psel & ~penable;    // setup phase
   wire         wrEn    = psel & penable & pwrite & pready;
   wire         hitS1D  = idx == IDX_S1D;
   wire         hitS2A  = idx == IDX_S2A;
   wire         hitRte  = idx == IDX_ROUTE;
   wire         hitStat = idx == IDX_STAT;
   wire         mapped  = hitS1D | hitS2A | hitRte | hitStat;

   logic [NCH-1:0][23:0] shadow_r;            // word as software wrote it
   logic [NCH-1:0][2:0]  lanes_r;             // bytes written since commit
   cfg_t [NCH-1:0]       active_r;            // word the divider runs on
   logic [NCH-1:0]       route_r;             // routed to configurable pin
   logic [NCH-1:0]       outs;                // channel outputs
   logic [NCH-1:0]       ticks;               // VCO enables per channel
   logic [NCH-1:0][3:0]  rels;                // related clocks per channel
   logic [NCH-1:0]       hits;                // write hits per channel
   logic [NCH-1:0]       fpMode;              // channel in frame mode
   logic [NCH-1:0]       overMax;             // divisor beyond ceiling

   assign hits  = {hitS2A, hitS1D};
   assign ticks = {vco2Tick, vco1Tick};
   // code 0 of synth2 A and code 3 of synth1 D are reserved, tied low
   assign rels  = {{s2RelD, s2RelC, s2RelB, 1'b0}, {1'b0, s1RelC, s1RelB, s1RelA}};

   ////////////////////////////////////////////////////////////////////////////
   // per-channel byte assembly and commit
   genvar ch;
   genvar b;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         localparam logic [23:0] RSTV = (ch == 0) ? RST_S1D : RST_S2A;
         localparam logic [1:0]  RSV  = (ch == 0) ? RSV_S1D : RSV_S2A;
         wire        hitW   = wrEn & hits[ch];
         wire [2:0]  lanesN = lanes_r[ch] | pstrb[2:0];
         logic [23:0] merged;                 // shadow with this write merged

         // only strobed bytes replace their shadow byte
         for (b = 0; b < 3; b++) begin : g_b
            assign merged[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] : shadow_r[ch][8*b +: 8];
         end

         assign fpMode[ch]  = active_r[ch].shape == SHAPE_FP;
         assign overMax[ch] = !fpMode[ch] && active_r[ch] > MAX_DIV;

         // a half-written word never reaches the divider
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               shadow_r[ch] <= RSTV;
               lanes_r[ch]  <= 3'h0;
               active_r[ch] <= RSTV;
            end else if (hitW) begin
               shadow_r[ch] <= merged;
               if (lanesN == ALL_LANES) begin
                  active_r[ch] <= merged;
                  lanes_r[ch]  <= 3'h0;
               end else begin
                  lanes_r[ch]  <= lanesN;
               end
            end
         end

         post_div_channel #(.RSV_SEL(RSV)) u_chan (
            .clk     (clk),
            .rst     (rst),
            .cfg     (active_r[ch]),
            .vcoTick (ticks[ch]),
            .relClk  (rels[ch]),
            .invert  (route_r[ch]),
            .clkOut  (outs[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // routing bits and status word
   wire [31:0] status = {20'h00000, overMax, fpMode, lanes_r[1], lanes_r[0], outs};
   wire [31:0] rdMux  = hitS1D ? {8'h00, shadow_r[0]} :
                        hitS2A ? {8'h00, shadow_r[1]} :
                        hitRte ? {30'h00000000, route_r} :
                        hitStat ? status : 32'h00000000;

   // routing register; bits above NCH read as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_r <= 2'h0;
      end else if (wrEn && hitRte && pstrb[0]) begin
         route_r <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer: ready one cycle after setup, dropped after the handshake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h00000000 : rdMux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs registered once more so they come straight from flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         synth1DivisorD <= 1'b0;
         synth2DivisorA <= 1'b0;
      end else begin
         synth1DivisorD <= outs[0];
         synth2DivisorA <= outs[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_commit;
      @(posedge clk) disable iff (rst)
      !(wrEn && hitS1D && (lanes_r[0] | pstrb[2:0]) == ALL_LANES) |=> $stable(active_r[0]);
   endproperty
   a_commit: assert property (p_commit) else $error("partial word applied");

   property p_full;
      @(posedge clk) disable iff (rst)
      wrEn && hitS2A && pstrb[2:0] == ALL_LANES && lanes_r[1] == 3'h0
      |=> active_r[1] == $past(pwdata[23:0]) && lanes_r[1] == 3'h0;
   endproperty
   a_full: assert property (p_full) else $error("full word not applied");

   property p_ready;
      @(posedge clk) disable iff (rst)
      setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("apb ready timing");

   property p_out2;
      @(posedge clk) disable iff (rst)
      1'b1 |=> synth2DivisorA == $past(outs[1]);
   endproperty
   a_out2: assert property (p_out2) else $error("synth2 A output lost");

endmodule

// ===== synth_post_divider_frame_pulse_tb_top.sv
// Purpose: self-checking bench for the post-divider registers and both outputs
// Assumes: APB slave answers one cycle into the access phase, outputs registered
// Notes:   related clocks share one phase counter, giving periods of 4, 8 and 16
module synth_post_divider_frame_pulse_tb_top
   import post_div_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   typedef struct {int ch; logic [23:0] w; int hi; int per;} row_t;
   localparam int LIMIT = 20000;                 // ceiling, tests need about 1000
   logic        clk, rst, psel, penable, pwrite; // clock, reset, apb controls
   logic [9:0]  paddr;                           // apb byte address
   logic [31:0] pwdata, prdata, rd;              // apb data
   logic [3:0]  pstrb;                           // byte strobes
   logic        pready, pslverr, er;             // apb answer
   logic        vco1Tick;                        // synth1 vco runs every cycle
   logic [3:0]  ph = 4'h0;                       // related clock phase
   wire  [1:0]  outs;                            // {synth2 A, synth1 D}
   int          errTotal, checks, cyc, hi, per, pg, ps, n;
   // normal divisors stay below the ceiling, no channel relates to itself
   row_t rows [10] = '{'{0, 24'h000005, 3, 5}, '{0, 24'h000004, 2, 4},
      '{1, 24'h000003, 4, 6}, '{0, 24'hF80003, 8, 24}, '{0, 24'hF10002, 4, 8},
      '{0, 24'hF20002, 16, 32}, '{1, 24'hF90003, 8, 24}, '{1, 24'hF20003, 4, 12},
      '{1, 24'hF30002, 16, 32}, '{1, 24'hF50003, 16, 24}};
   ////////////////////////////////////////////////////////////////////////////
   post_div_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .vco1Tick(vco1Tick),
      .vco2Tick(ph[0]), .s1RelA(ph[2]), .s1RelB(ph[1]), .s1RelC(ph[3]),
      .s2RelB(ph[2]), .s2RelC(ph[1]), .s2RelD(ph[3]),
      .synth1DivisorD(outs[0]), .synth2DivisorA(outs[1]));
   ////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // phase counter makes every related clock, moved at the edge like any input
   always @(posedge clk) begin
      ph <= ph + 4'h1;
   end
   // hang guard, counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errTotal++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errTotal++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [9:0] adr(input int ch);
      return (ch != 0) ? {IDX_S2A, 2'b00} : {IDX_S1D, 2'b00};
   endfunction
   // high time and phase of the second output rise, period to the third; the first is skipped
   // because the cycle running when the word changed may be cut short
   task automatic meas(input int ch);
      logic prev;
      int   r;
      int   t0;
      hi = -1;
      per = -1;
      r = 0;
      t0 = 0;
      prev = outs[ch];
      for (int t = 0; t < 600 && per < 0; t++) begin
         @(posedge clk);
         if (outs[ch] === 1'b1 && prev === 1'b0) begin
            r++;
            if (r == 3) begin
               per = t - t0;
            end else if (r == 2) begin
               t0 = t;
               pg = ph[2:0];
            end
         end
         if (outs[ch] === 1'b0 && prev === 1'b1 && r == 2) begin
            hi = t - t0;
         end
         prev = outs[ch];
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence: table of channel words first, then hand-written cases
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {errTotal, checks, cyc} = '0;
      rst = 1'b1;
      vco1Tick = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, adr(rows[i].ch), {8'h00, rows[i].w}, 4'h7);
         apb(1'b0, adr(rows[i].ch), 32'h0, 4'h0);
         chk(rd, {8'h00, rows[i].w});
         meas(rows[i].ch);
         chk(hi, rows[i].hi);
         chk(per, rows[i].per);
         $display("table row %0d done", i);
      end
      // routing to a configurable pin flips each channel's pulse polarity
      apb(1'b1, adr(0), 32'h00F1_0003, 4'h7);
      apb(1'b1, {IDX_ROUTE, 2'b00}, 32'h0000_0003, 4'hF);
      apb(1'b0, {IDX_ROUTE, 2'b00}, 32'h0, 4'h0);
      chk(rd, 32'h0000_0003);
      meas(1);
      chk(hi, 8);
      chk(per, 24);
      meas(0);
      chk(hi, 8);
      chk(per, 12);
      apb(1'b1, {IDX_ROUTE, 2'b00}, 32'h0, 4'hF);
      $display("routing test done");
      // edge framing rises half a related period after mid-pulse framing
      apb(1'b1, adr(1), 32'h00F9_0002, 4'h7);
      meas(1);
      ps = pg;
      apb(1'b1, adr(1), 32'h00F1_0002, 4'h7);
      meas(1);
      chk(hi, 8);
      chk((ps - pg) & 7, 4);
      $display("framing test done");
      // a half-written word must not reach the divider
      apb(1'b1, adr(0), 32'h0000_0005, 4'h7);
      apb(1'b1, adr(0), 32'h0000_0004, 4'h3);
      // status shows two pending bytes for synth1 D and frame mode on synth2 A
      apb(1'b0, {IDX_STAT, 2'b00}, 32'h0, 4'h0);
      chk(rd & 32'h0000_0FFC, 32'h0000_020C);
      meas(0);
      chk(per, 5);
      apb(1'b1, adr(0), 32'h0000_0000, 4'h4);
      meas(0);
      chk(per, 4);
      chk(hi, 2);
      $display("partial write test done");
      // reserved related-clock codes give no pulse at all
      apb(1'b1, adr(0), 32'h00F3_0002, 4'h7);
      apb(1'b1, adr(1), 32'h00F0_0002, 4'h7);
      repeat (8) @(posedge clk);
      n = 0;
      repeat (64) begin
         @(posedge clk);
         n += (outs !== 2'b00);
      end
      chk(n, 0);
      // both channels in frame mode, nothing pending, both outputs low
      apb(1'b0, {IDX_STAT, 2'b00}, 32'h0, 4'h0);
      chk(rd, 32'h0000_0300);
      $display("reserved select test done");
      // second reset: outputs low, registers back to their reset words
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      chk(outs, 2'b00);
      rst <= 1'b0;
      apb(1'b0, adr(0), 32'h0, 4'h0);
      chk(rd, {8'h00, RST_S1D});
      apb(1'b0, adr(1), 32'h0, 4'h0);
      chk(rd, {8'h00, RST_S2A});
      apb(1'b0, 10'h000, 32'h0, 4'h0);
      chk({rd[30:0], er}, 32'h0000_0001);
      $display("reset test done");
      end_of_test();
   end
endmodule
